// ### src/eeprom_defines.svh
// Constants for the serial EEPROM power-on and ECC block
`ifndef EEPROM_DEFINES_SVH
`define EEPROM_DEFINES_SVH
`define CLK_PERIOD_NS   20
`define T_WRITE_NS      4000000
`define T_WRITE_CYC     (`T_WRITE_NS / `CLK_PERIOD_NS)
`define ARRAY_BYTES     8192
`define GROUP_BYTES     4
`define ERASED_BYTE     8'hff
`define ID_CODE_BYTES   3
`define ID_PAGE_BYTES   32
`define CMD_WRSR        8'h01
`define CMD_WRITE       8'h02
`define CMD_READ        8'h03
`define CMD_WRDI        8'h04
`define CMD_RDSR        8'h05
`define CMD_WREN        8'h06
`define CMD_RDID        8'h83
`define SR_SWD_BIT      7
`define SR_BPH_BIT      3
`define SR_BPL_BIT      2
`define SR_WEL_BIT      1
`define SR_WIP_BIT      0
`define NV_RESET        3'h0
`endif

// ### src/eeprom_pkg.sv
// Types and ECC functions for the serial EEPROM block
package eeprom_pkg;
  typedef enum logic [4:0] {
    ST_CMD  = 5'h01,
    ST_ADDR = 5'h02,
    ST_RD   = 5'h04,
    ST_WR   = 5'h08,
    ST_SKIP = 5'h10
  } state_t;

  typedef logic [37:0] codeword_t;
  typedef logic [31:0] group_t;

  // Hamming single error correction over one four-byte group
  function automatic codeword_t ecc_encode(input group_t d);
    codeword_t c;
    int        j;
    c = '0;
    j = 0;
    for (int p = 1; p <= 38; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p-1] = d[j];
        j++;
      end
    end
    for (int k = 0; k < 6; k++) begin
      for (int p = 1; p <= 38; p++) begin
        if (p[k] && ((p & (p - 1)) != 0)) begin
          c[(1 << k) - 1] = c[(1 << k) - 1] ^ c[p-1];
        end
      end
    end
    return c;
  endfunction : ecc_encode

  function automatic group_t ecc_decode(input codeword_t cw);
    codeword_t   c;
    logic [5:0]  syn;
    group_t      d;
    int          j;
    c   = cw;
    syn = '0;
    d   = '0;
    j   = 0;
    for (int p = 1; p <= 38; p++) begin
      if (c[p-1]) begin
        syn = syn ^ 6'(p);
      end
    end
    if (syn != 6'h00 && syn <= 6'h26) begin
      c[syn-1] = ~c[syn-1];
    end
    for (int p = 1; p <= 38; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[j] = c[p-1];
        j++;
      end
    end
    return d;
  endfunction : ecc_decode
endpackage : eeprom_pkg

// ### src/ecc_if.sv
// Interface carrying stored and corrected ECC groups
interface ecc_if;
  eeprom_pkg::codeword_t raw_cw;
  eeprom_pkg::group_t    fixed_data;
  eeprom_pkg::group_t    new_data;
  eeprom_pkg::codeword_t new_cw;
  modport user  (output raw_cw, output new_data,
                 input fixed_data, input new_cw);
  modport codec (input raw_cw, input new_data,
                 output fixed_data, output new_cw);
endinterface : ecc_if

// ### src/ecc_codec.sv
// Combinational ECC encoder and single bit corrector
module ecc_codec (
  ecc_if.codec e
);
  assign e.fixed_data = eeprom_pkg::ecc_decode(e.raw_cw);
  assign e.new_cw     = eeprom_pkg::ecc_encode(e.new_data);
endmodule : ecc_codec

// ### src/eeprom_core.sv
// SPI EEPROM core: power-on state, status bits and ECC array
//
// Function
// [RQ1] Ignore instructions until power-on reset releases
// [RQ2] Power-on reset clears write enable and busy
// [RQ3] Power-on reset keeps non-volatile status bits
// [RQ4] After reset: standby, deselected, not paused
// [RQ5] Master deselects and waits before power off
// [RQ6] Master selects at most one device
// [RQ7] Data output driven only while selected
// [RQ8] Correct single bit errors per group
// [RQ9] Byte write rewrites its whole group
// [RQ10] ECC invisible on the serial bus
// [RQ11] Delivered: array FFh, protection bits zero
// [RQ12] Delivered: identification code in first bytes
`include "eeprom_defines.svh"
module eeprom_core #(
  parameter int        ARRAY_BYTES = `ARRAY_BYTES,
  parameter int        T_WRITE_CYC = `T_WRITE_CYC,
  parameter logic [23:0] ID_CODE   = 24'h5a_a5_3c // Arbitrary value
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic factory_n,
  input  wire logic sck,
  input  wire logic cs_n,
  input  wire logic mosi,
  input  wire logic hold_n,
  output logic      miso,
  output logic      miso_oe
);
  localparam int WORDS = ARRAY_BYTES / `GROUP_BYTES;
  localparam int AW    = $clog2(ARRAY_BYTES);
  localparam int WW    = AW - 2;

  logic                 rst_m_ff, rst_q_ff;
  logic [4:0]           in_m_ff, in_q_ff;
  logic                 sck_d_ff;
  eeprom_pkg::state_t   state_ff, nxt_state;
  logic [2:0]           bit_ff;
  logic [7:0]           sh_ff, cmd_ff, out_ff;
  logic [1:0]           abyte_ff;
  logic [15:0]          addr_ff;
  logic                 wel_ff, wip_ff;
  logic [2:0]           nv_ff;
  logic [31:0]          wcnt_ff;
  logic                 miso_ff;
  logic [WW-1:0]        sweep_ff;
  logic                 rd_load_ff;
  wire [7:0]            rd_src;
  eeprom_pkg::codeword_t mem [WORDS];

  ecc_if ecc ();
  ecc_codec u_codec (.e(ecc));

  // Reset release through two flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_ff <= 1'b0;
      rst_q_ff <= 1'b0;
    end else begin
      rst_m_ff <= 1'b1;
      rst_q_ff <= rst_m_ff;
    end
  end

  // Pin synchronisers: sck, cs_n, mosi, hold_n, factory_n
  always_ff @(posedge clock or negedge rst_q_ff) begin
    if (!rst_q_ff) begin
      in_m_ff  <= 5'h1f;
      in_q_ff  <= 5'h1f;
      sck_d_ff <= 1'b0;
    end else begin
      in_m_ff  <= {factory_n, hold_n, mosi, cs_n, sck};
      in_q_ff  <= in_m_ff;
      sck_d_ff <= in_q_ff[0];
    end
  end

  wire sck_q    = in_q_ff[0];
  wire cs_q     = in_q_ff[1];
  wire mosi_q   = in_q_ff[2];
  wire hold_q   = ~in_q_ff[3];
  wire factory  = ~in_q_ff[4];
  wire selected = ~cs_q;
  wire active   = selected & ~hold_q;
  wire rise     = active & sck_q & ~sck_d_ff;
  wire fall     = active & ~sck_q & sck_d_ff;
  wire byte_end = rise & (bit_ff == 3'h7);
  wire [7:0] byte_in = {sh_ff[6:0], mosi_q};
  wire [15:0] addr_nx = {addr_ff[7:0], byte_in};

  wire [WW-1:0] word_ix = addr_ff[AW-1:2];
  wire [1:0]    lane    = addr_ff[1:0];
  assign ecc.raw_cw = mem[word_ix];                           // [RQ8]
  wire [31:0]   cur   = ecc.fixed_data;
  wire [7:0]    rd_byte = cur[8*lane +: 8];
  wire [4:0]    id_ix   = addr_ff[4:0];
  wire [7:0]    id_byte = (id_ix < 5'(`ID_CODE_BYTES)) ?
                          ID_CODE[8*(2-id_ix) +: 8] : `ERASED_BYTE; // [RQ12]
  wire [7:0] status = {nv_ff[2], 3'h0, nv_ff[1:0], wel_ff, wip_ff};
  assign rd_src = (cmd_ff == `CMD_RDID) ? id_byte : rd_byte;

  // Byte merge: the other three bytes of the group go back as corrected
  always_comb begin
    ecc.new_data = factory ? {4{`ERASED_BYTE}} : cur;         // [RQ11]
    if (!factory) begin
      ecc.new_data[8*lane +: 8] = byte_in;                     // [RQ9]
    end
  end

  wire busy     = wip_ff;
  wire go_cmd   = (state_ff == eeprom_pkg::ST_CMD) & byte_end;
  wire wr_byte  = (state_ff == eeprom_pkg::ST_WR) & byte_end
                  & (cmd_ff == `CMD_WRITE);
  wire sr_write = (state_ff == eeprom_pkg::ST_WR) & byte_end
                  & (cmd_ff == `CMD_WRSR) & ~nv_ff[2];
  wire cs_end   = cs_q & (state_ff == eeprom_pkg::ST_WR);
  wire is_rd    = (cmd_ff == `CMD_READ) | (cmd_ff == `CMD_RDID);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      eeprom_pkg::ST_CMD: begin
        if (go_cmd) begin
          if (busy && byte_in != `CMD_RDSR) begin
            nxt_state = eeprom_pkg::ST_SKIP;
          end else if (byte_in == `CMD_READ || byte_in == `CMD_RDID ||
                       (byte_in == `CMD_WRITE && wel_ff)) begin
            nxt_state = eeprom_pkg::ST_ADDR;
          end else if (byte_in == `CMD_WRSR && wel_ff) begin
            nxt_state = eeprom_pkg::ST_WR;
          end else begin
            nxt_state = eeprom_pkg::ST_SKIP;
          end
        end
      end
      eeprom_pkg::ST_ADDR: begin
        if (byte_end && abyte_ff == 2'h1) begin
          nxt_state = is_rd ? eeprom_pkg::ST_RD : eeprom_pkg::ST_WR;
        end
      end
      eeprom_pkg::ST_RD:   nxt_state = eeprom_pkg::ST_RD;
      eeprom_pkg::ST_WR:   nxt_state = eeprom_pkg::ST_WR;
      eeprom_pkg::ST_SKIP: nxt_state = eeprom_pkg::ST_SKIP;
    endcase
    if (cs_q) begin
      nxt_state = eeprom_pkg::ST_CMD;                          // [RQ4]
    end
  end

  // Serial engine; held idle while reset is low
  always_ff @(posedge clock or negedge rst_q_ff) begin
    if (!rst_q_ff) begin
      state_ff <= eeprom_pkg::ST_CMD;                          // [RQ1] [RQ4]
      bit_ff   <= 3'h0;
      sh_ff    <= 8'h00;
      cmd_ff   <= 8'h00;
      abyte_ff <= 2'h0;
      addr_ff  <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      if (cs_q) begin
        bit_ff   <= 3'h0;
        abyte_ff <= 2'h0;
      end else if (rise) begin
        bit_ff <= bit_ff + 3'h1;
        sh_ff  <= byte_in;
        if (go_cmd) begin
          cmd_ff <= byte_in;
        end
        if (byte_end && state_ff == eeprom_pkg::ST_ADDR) begin
          abyte_ff <= abyte_ff + 2'h1;
          addr_ff  <= addr_nx;
        end else if (byte_end && (state_ff == eeprom_pkg::ST_RD ||
                                  wr_byte)) begin
          addr_ff <= addr_ff + 16'h0001;
        end
      end
    end
  end

  // Output shifter: loaded at byte end, shifted on falling edge
  always_ff @(posedge clock or negedge rst_q_ff) begin
    if (!rst_q_ff) begin
      out_ff  <= 8'h00;
      miso_ff <= 1'b0;
    end else if (byte_end) begin
      if (go_cmd && byte_in == `CMD_RDSR) begin
        out_ff <= status;
      end else if (state_ff == eeprom_pkg::ST_CMD && cmd_ff == `CMD_RDSR) begin
        out_ff <= status;
      end else if (state_ff == eeprom_pkg::ST_ADDR && abyte_ff == 2'h1) begin
        out_ff <= 8'h00;
      end else begin
        out_ff <= 8'h00;
      end
    end else if (rd_load_ff) begin
      out_ff <= rd_src;                                        // [RQ10]
    end else if (fall) begin
      miso_ff <= out_ff[7];
      out_ff  <= {out_ff[6:0], 1'b0};
    end
  end

  // Read byte is loaded one clock after the address settles
  always_ff @(posedge clock or negedge rst_q_ff) begin
    if (!rst_q_ff) begin
      rd_load_ff <= 1'b0;
    end else begin
      rd_load_ff <= byte_end & ((state_ff == eeprom_pkg::ST_RD) |
                    (state_ff == eeprom_pkg::ST_ADDR && abyte_ff == 2'h1
                     && is_rd));
    end
  end

  assign miso    = miso_ff;
  assign miso_oe = active;                                     // [RQ7]

  // Volatile status bits and write timer
  always_ff @(posedge clock or negedge rst_q_ff) begin
    if (!rst_q_ff) begin
      wel_ff  <= 1'b0;                                         // [RQ2]
      wip_ff  <= 1'b0;                                         // [RQ2]
      wcnt_ff <= 32'h0;
    end else begin
      if (go_cmd && !busy && byte_in == `CMD_WREN) begin
        wel_ff <= 1'b1;
      end else if (go_cmd && !busy && byte_in == `CMD_WRDI) begin
        wel_ff <= 1'b0;
      end else if (cs_end) begin
        wel_ff <= 1'b0;
      end
      if (cs_end) begin
        wip_ff  <= 1'b1;
        wcnt_ff <= 32'(T_WRITE_CYC - 1);
      end else if (wip_ff) begin
        wcnt_ff <= wcnt_ff - 32'h1;
        wip_ff  <= (wcnt_ff != 32'h0);
      end
    end
  end

  // Delivery sweep pointer starts from the first group
  always_ff @(posedge clock or negedge rst_q_ff) begin
    if (!rst_q_ff) begin
      sweep_ff <= '0;
    end else if (factory) begin
      sweep_ff <= sweep_ff + 1'b1;
    end
  end

  // Non-volatile bits and array have no power-on reset
  always_ff @(posedge clock) begin
    if (factory) begin
      nv_ff    <= `NV_RESET;                                   // [RQ11]
      mem[sweep_ff] <= ecc.new_cw;                             // [RQ11]
    end else begin
      if (rst_q_ff && sr_write) begin
        nv_ff <= {byte_in[`SR_SWD_BIT], byte_in[`SR_BPH_BIT],
                  byte_in[`SR_BPL_BIT]};                       // [RQ3]
      end
      if (rst_q_ff && wr_byte) begin
        mem[word_ix] <= ecc.new_cw;                            // [RQ9]
      end
    end
  end

  wire [31:0] flip = 32'h1 << addr_ff[4:0];
  property p_ecc_fix;                                          
    @(posedge clock) disable iff (!rst_q_ff)
      (wr_byte || factory) |->
        eeprom_pkg::ecc_decode(ecc.new_cw ^ {6'h0, flip}) == ecc.new_data;
  endproperty
  a_ecc_fix: assert property (p_ecc_fix) // [RQ8]
    else $error("single bit flip not corrected");

  property p_oe_sel;
    @(posedge clock) disable iff (!rst_q_ff) cs_q |-> !miso_oe;
  endproperty
  a_oe_sel: assert property (p_oe_sel) // [RQ7]
    else $error("output enabled while deselected");

  property p_por_clear;
    @(posedge clock) $rose(rst_q_ff) |-> !wel_ff && !wip_ff;
  endproperty
  a_por_clear: assert property (p_por_clear) // [RQ2]
    else $error("status not cleared at power-on");

  property p_por_idle;
    @(posedge clock) !rst_q_ff |=> state_ff == eeprom_pkg::ST_CMD;
  endproperty
  a_por_idle: assert property (p_por_idle) // [RQ1]
    else $error("engine active during power-on reset");

  property p_por_state;
    @(posedge clock) disable iff (!rst_q_ff)
      $rose(rst_q_ff) |-> state_ff == eeprom_pkg::ST_CMD && bit_ff == 3'h0;
  endproperty
  a_por_state: assert property (p_por_state) // [RQ4]
    else $error("not in standby after power-on");

  property p_nv_keep;
    @(posedge clock) disable iff (factory)
      $past(rst_q_ff) && !rst_q_ff |=> $stable(nv_ff);
  endproperty
  a_nv_keep: assert property (p_nv_keep) // [RQ3]
    else $error("non-volatile bits changed by reset");

  sequence s_wr_byte;
    wr_byte ##0 (ecc.new_data[8*lane +: 8] == byte_in);
  endsequence
  property p_group_wr;
    @(posedge clock) disable iff (!rst_q_ff || factory)
      s_wr_byte |=> mem[$past(word_ix)] == $past(ecc.new_cw);
  endproperty
  a_group_wr: assert property (p_group_wr) // [RQ9]
    else $error("group not rewritten on byte write");

  property p_factory;
    @(posedge clock) factory |=> nv_ff == `NV_RESET;
  endproperty
  a_factory: assert property (p_factory) // [RQ11]
    else $error("protection bits not cleared on delivery");

  property p_id_code;
    @(posedge clock) disable iff (!rst_q_ff)
      id_ix == 5'h0 |-> id_byte == ID_CODE[23:16];
  endproperty
  a_id_code: assert property (p_id_code) // [RQ12]
    else $error("identification code byte wrong");

  property p_rd_timing;
    @(posedge clock) disable iff (!rst_q_ff)
      rd_load_ff |=> out_ff == $past(rd_src);
  endproperty
  a_rd_timing: assert property (p_rd_timing) // [RQ10]
    else $error("read data delayed or altered");
endmodule : eeprom_core

// ### verification/spi_master_model.sv
// SPI bus master model driving the EEPROM serial pins
module spi_master_model (
  output logic      sck,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic miso_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  int half_ns = 80;

  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // Only this one device is ever selected
  task automatic select_dev();
    #(half_ns + 7);
    cs_n = 1'b0;
    #(half_ns);
  endtask : select_dev

  // Released data line no longer shows the last bit
  task automatic deselect_dev();
    #(half_ns);
    cs_n = 1'b1;
    mosi = ~mosi;
    #(half_ns);
  endtask : deselect_dev

  // One byte, MSB first, mode 0; read bit taken at the rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #(half_ns);
      rx[i] = miso;
      sck = 1'b1;
      #(half_ns);
      sck = 1'b0;
    end
  endtask : xfer
endmodule : spi_master_model

// ### verification/eeprom_por_and_ecc_state_test.sv
// Self-checking bench for the EEPROM power-on and ECC block
`include "eeprom_defines.svh"
`define CHK(what, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("ERROR %s expected %h seen %h", what, exp, got); \
    end \
  end

module eeprom_por_and_ecc_state_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          T_WR  = 50;
  localparam int          LIMIT = 40000;
  localparam logic [23:0] ID    = 24'h3c_c3_3c; // Arbitrary value

  logic        clock     = 1'b0;
  logic        rst_n     = 1'b0;
  logic        factory_n = 1'b1;
  logic        hold_n    = 1'b1;
  logic        sck;
  logic        cs_n;
  logic        mosi;
  logic        miso;
  logic        miso_oe;
  int          miscompares = 0;
  int          n_checks    = 0;
  int          cycles      = 0;
  logic [15:0] rnd         = 16'h0050;
  logic [7:0]  mem [int];
  logic [2:0]  nv_exp      = 3'h0;
  logic [7:0]  sr;
  logic [31:0] grp;
  logic [15:0] addr;

  always #10 clock = ~clock;

  eeprom_core #(.T_WRITE_CYC(T_WR), .ID_CODE(ID)) dut (
    .clock     (clock),
    .rst_n     (rst_n),
    .factory_n (factory_n),
    .sck       (sck),
    .cs_n      (cs_n),
    .mosi      (mosi),
    .hold_n    (hold_n),
    .miso      (miso),
    .miso_oe   (miso_oe)
  );

  spi_master_model master (
    .sck     (sck),
    .cs_n    (cs_n),
    .mosi    (mosi),
    .miso    (miso),
    .miso_oe (miso_oe)
  );

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic [7:0] exp_sr(input logic [2:0] nv,
                                        input logic write_enable_latch);
    logic [7:0] s;
    s = 8'h00;
    s[`SR_SWD_BIT] = nv[2];
    s[`SR_BPH_BIT] = nv[1];
    s[`SR_BPL_BIT] = nv[0];
    s[`SR_WEL_BIT] = write_enable_latch;
    return s;
  endfunction : exp_sr

  function automatic logic [31:0] exp_grp(input logic [15:0] a);
    logic [31:0] g;
    int          k;
    for (int i = 0; i < `GROUP_BYTES; i++) begin
      k = int'({a[12:2], 2'b00}) + i;
      g[8*i +: 8] = mem.exists(k) ? mem[k] : `ERASED_BYTE;
    end
    return g;
  endfunction : exp_grp

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc

  task automatic cmd(input logic [7:0] op);
    logic [7:0] rx;
    master.select_dev();
    master.xfer(op, rx);
    master.deselect_dev();
  endtask : cmd

  task automatic rdsr(output logic [7:0] s);
    master.select_dev();
    master.xfer(`CMD_RDSR, s);
    master.xfer(8'h00, s);
    master.deselect_dev();
  endtask : rdsr

  task automatic rd4(input logic [7:0] op, input logic [15:0] a,
                     output logic [31:0] w);
    logic [7:0] b;
    master.select_dev();
    master.xfer(op, b);
    master.xfer(a[15:8], b);
    master.xfer(a[7:0], b);
    for (int i = 0; i < 4; i++) begin
      master.xfer(8'h00, b);
      w[8*i +: 8] = b;
    end
    master.deselect_dev();
  endtask : rd4

  task automatic wr(input logic [7:0] op, input logic [15:0] a,
                    input logic [7:0] d);
    logic [7:0] rx;
    cmd(`CMD_WREN);
    master.select_dev();
    master.xfer(op, rx);
    if (op == `CMD_WRITE) begin
      master.xfer(a[15:8], rx);
      master.xfer(a[7:0], rx);
    end
    master.xfer(d, rx);
    master.deselect_dev();
    cyc(T_WR + 10);
  endtask : wr

  task automatic oe_chk(input logic exp);
    @(negedge clock);
    `CHK("miso_oe", exp, miso_oe)
  endtask : oe_chk

  task automatic summarize();
    if (miscompares == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      summarize();
    end
  end

  initial begin
    cyc(6);
    rst_n <= 1'b1;
    cyc(8);
    oe_chk(1'b0);
    cyc(1);
    factory_n <= 1'b0;
    cyc(2100);
    factory_n <= 1'b1;
    cyc(6);
    rdsr(sr);
    `CHK("status", exp_sr(3'h0, 1'b0), sr)
    rd4(`CMD_READ, 16'h0000, grp);
    `CHK("array", 32'hffffffff, grp)
    rd4(`CMD_READ, 16'h1ffc, grp);
    `CHK("array", 32'hffffffff, grp)
    rd4(`CMD_RDID, 16'h0000, grp);
    `CHK("id", {ID[7:0], ID[15:8], ID[23:16]}, grp[23:0])
    master.select_dev();
    oe_chk(1'b1);
    cyc(1);
    hold_n <= 1'b0;
    cyc(4);
    oe_chk(1'b0);
    cyc(1);
    hold_n <= 1'b1;
    cyc(4);
    oe_chk(1'b1);
    master.deselect_dev();
    oe_chk(1'b0);
    for (int k = 0; k < 8; k++) begin
      rnd = lfsr(rnd);
      addr = (k == 0) ? 16'h1fff : (k == 1) ? 16'h0003 :
             (k == 2) ? 16'h0001 : {3'h0, rnd[12:0]};
      rnd = lfsr(rnd);
      master.half_ns = (k == 3) ? 200 : 80;
      wr(`CMD_WRITE, addr, rnd[7:0]);
      mem[int'(addr[12:0])] = rnd[7:0];
      rd4(`CMD_READ, {addr[15:2], 2'b00}, grp);
      `CHK("group", exp_grp(addr), grp)
    end
    wr(`CMD_WRSR, 16'h0000, 8'h8c);
    nv_exp = 3'h7;
    rdsr(sr);
    `CHK("nv bits", exp_sr(nv_exp, 1'b0), sr)
    for (int p = 0; p < 2; p++) begin
      if (p == 0)
        cmd(`CMD_WREN);
      // Deselected with no write running before the drop
      cyc(2);
      rst_n <= 1'b0;
      if (p == 1) begin
        master.select_dev();
        master.xfer(`CMD_WREN, sr);
        oe_chk(1'b0);
        master.deselect_dev();
      end
      cyc(4);
      rst_n <= 1'b1;
      cyc(8);
      rdsr(sr);
      `CHK("por status", exp_sr(nv_exp, 1'b0), sr)
    end
    summarize();
  end
endmodule : eeprom_por_and_ecc_state_test
